/* logic/eeprom_pkg.sv */
// shared constants and types of the serial word memory
`default_nettype none

package eeprom_pkg;

    // ------------------------------------------------------------
    // word and address layout
    // ------------------------------------------------------------
    localparam int          WORD_BITS         = 16;
    localparam int          MAX_ADDR_BITS     = 10;
    localparam int          DEFAULT_ADDR_BITS = 6;
    localparam logic [15:0] ERASED_WORD       = 16'hffff;
    localparam int          OPCODE_CLOCKS     = 2;
    localparam int          FIFO_DEPTH        = 4;

    // ------------------------------------------------------------
    // operation codes and sub codes of the special group
    // ------------------------------------------------------------
    localparam logic [1:0]  OP_SPECIAL        = 2'h0;
    localparam logic [1:0]  OP_WRITE          = 2'h1;
    localparam logic [1:0]  OP_READ           = 2'h2;
    localparam logic [1:0]  OP_ERASE          = 2'h3;
    localparam logic [1:0]  SUB_PROG_DISABLE  = 2'h0;
    localparam logic [1:0]  SUB_WRITE_ALL     = 2'h1;
    localparam logic [1:0]  SUB_ERASE_ALL     = 2'h2;
    localparam logic [1:0]  SUB_PROG_ENABLE   = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLOCK_PERIOD_NS   = 25;
    localparam int          WRITE_TIME_NS     = 4000000;
    // longest time: round down
    localparam int          WRITE_CYCLES      =
        (WRITE_TIME_NS / CLOCK_PERIOD_NS < 1) ? 1 :
        WRITE_TIME_NS / CLOCK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FRAME_IDLE    = 3'h0,
        FRAME_OPCODE  = 3'h1,
        FRAME_ADDRESS = 3'h2,
        FRAME_DATA    = 3'h3,
        FRAME_READ    = 3'h4,
        FRAME_ARMED   = 3'h5,
        FRAME_CANCEL  = 3'h6,
        FRAME_HOLD    = 3'h7
    } frame_state_type;

    typedef enum logic [1:0] {
        JOB_WRITE     = 2'h0,
        JOB_ERASE     = 2'h1,
        JOB_WRITE_ALL = 2'h2,
        JOB_ERASE_ALL = 2'h3
    } job_op_type;

    typedef struct packed {
        job_op_type                 op;
        logic [MAX_ADDR_BITS-1:0]   addr;
        logic [WORD_BITS-1:0]       data;
    } job_type;

endpackage

`default_nettype wire

/* logic/job_fifo.sv */
// small first-in first-out buffer with valid/ready on both sides
`default_nettype none

module job_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
    logic             do_push;
    logic             do_pop;

    assign in_ready  = (count != (PTR_W+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    always_ff @(posedge clock)
    begin
        if (do_push)
            store[wr_ptr] <= in_data;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (do_pop)
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            if (do_push && !do_pop)
                count <= count + 1'b1;
            else if (do_pop && !do_push)
                count <= count - 1'b1;
        end
    end

endmodule

`default_nettype wire

/* logic/pin_sync.sv */
// two flip-flop synchroniser for asynchronous pins
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] first_stage;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            first_stage <= '0;
            sync_out    <= '0;
        end
        else
        begin
            first_stage <= async_in;
            sync_out    <= first_stage;
        end
    end

endmodule

`default_nettype wire

/* logic/serial_eeprom.sv */
// serial-side command decoder and word store of a 16-bit serial memory
`default_nettype none

// Overview of operation
// R1: sample all input bits on clock rise
// R2: serial output changes only on clock rise; the busy/ready status level changes when programming ends
// R3: host sends select, start, opcode, address, data
// R4: select low ends the command frame
// R5: host keeps select low for deselect time
// R6: select low means standby, inputs ignored
// R7: start bit is first rise with input high
// R8: leading zero clocks before start ignored
// R9: opcode 10 reads sixteen bits msb first
// R10: opcode 01 writes sixteen bits to address
// R11: opcode 11 erases one word
// R12: special 01 writes all words
// R13: special 10 erases all words
// R14: special 11 enables programming
// R15: special 00 disables programming
// R16: address field width from capacity
// R17: continued read clocks advance address
// R18: all words start as all ones
// R19: programming commands need program enable
// R20: select high after write shows busy/ready
// R21: output drives low after last address bit
// R22: extra clocks cancel pending write
// R23: select low discards partial command
module serial_eeprom #(
    parameter int ADDR_BITS    = eeprom_pkg::DEFAULT_ADDR_BITS,
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    input  wire logic CLOCK,
    input  wire logic RST_N,
    input  wire logic CHIP_SELECT,
    input  wire logic SERIAL_CLOCK_IN,
    input  wire logic SERIAL_DATA_IN,
    output logic      SERIAL_DATA_OUT,
    output logic      SERIAL_DATA_OUT_EN
);

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int FIELD_CLOCKS = ADDR_BITS + (ADDR_BITS % 2); // R16
    localparam int DEPTH        = 1 << ADDR_BITS;
    localparam int CNT_W        = $clog2(WRITE_CYCLES + 1);
    localparam int MAXA         = eeprom_pkg::MAX_ADDR_BITS;
    localparam int JOB_W        = $bits(eeprom_pkg::job_type);

    // ------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------
    logic [2:0] pins_sync;
    logic       cs_s;
    logic       sk_s;
    logic       di_s;
    logic       sk_prev;
    logic       sk_rise;

    pin_sync #(
        .WIDTH    (3)
    ) u_pin_sync (
        .clock    (CLOCK),
        .rst_n    (RST_N),
        .async_in ({CHIP_SELECT, SERIAL_CLOCK_IN, SERIAL_DATA_IN}),
        .sync_out (pins_sync)
    );

    assign cs_s    = pins_sync[2];
    assign sk_s    = pins_sync[1];
    assign di_s    = pins_sync[0];
    assign sk_rise = sk_s && !sk_prev; // R1

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            sk_prev <= 1'b0;
        else
            sk_prev <= sk_s;
    end

    // ------------------------------------------------------------
    // word store
    // ------------------------------------------------------------
    // contents survive reset; only the delivered state is all ones
    logic [15:0]          mem [DEPTH] =
        '{default: eeprom_pkg::ERASED_WORD}; // R18
    logic                 mem_we;
    logic [ADDR_BITS-1:0] mem_waddr;
    logic [15:0]          mem_wdata;

    always_ff @(posedge CLOCK)
    begin
        if (mem_we)
            mem[mem_waddr] <= mem_wdata;
    end

    // ------------------------------------------------------------
    // command frame
    // ------------------------------------------------------------
    eeprom_pkg::frame_state_type state;
    eeprom_pkg::job_op_type      job_op;
    logic [4:0]                  cnt;
    logic [1:0]                  opcode;
    logic [MAXA-1:0]             field;
    logic [MAXA-1:0]             next_field;
    logic [1:0]                  sub;
    logic [15:0]                 wdata;
    logic                        last_addr_clock;
    logic                        busy;
    logic                        prog_enable;

    assign next_field      = {field[MAXA-2:0], di_s};
    assign sub             = next_field[FIELD_CLOCKS-1 -: 2];
    assign last_addr_clock = cs_s && sk_rise &&
        state == eeprom_pkg::FRAME_ADDRESS &&
        cnt == 5'(FIELD_CLOCKS - 1);

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            state  <= eeprom_pkg::FRAME_IDLE;
            cnt    <= '0;
            opcode <= '0;
            field  <= '0;
            wdata  <= '0;
            job_op <= eeprom_pkg::JOB_WRITE;
        end
        else if (!cs_s)
        begin
            state <= eeprom_pkg::FRAME_IDLE; // R4 R6 R23
            cnt   <= '0;
        end
        else if (sk_rise)
        begin
            unique case (state)
                eeprom_pkg::FRAME_IDLE:
                begin
                    // low input bits are leading dummies
                    if (di_s && !busy)
                        state <= eeprom_pkg::FRAME_OPCODE; // R7 R8
                    cnt <= '0;
                end
                eeprom_pkg::FRAME_OPCODE:
                begin
                    opcode <= {opcode[0], di_s}; // R1
                    cnt    <= cnt + 1'b1;
                    if (cnt == 5'(eeprom_pkg::OPCODE_CLOCKS - 1))
                    begin
                        state <= eeprom_pkg::FRAME_ADDRESS;
                        cnt   <= '0;
                    end
                end
                eeprom_pkg::FRAME_ADDRESS:
                begin
                    field <= next_field;
                    cnt   <= cnt + 1'b1;
                    if (cnt == 5'(FIELD_CLOCKS - 1)) // R16
                    begin
                        cnt <= '0;
                        unique case (opcode)
                            eeprom_pkg::OP_READ:
                                state <= eeprom_pkg::FRAME_READ; // R9
                            eeprom_pkg::OP_WRITE:
                            begin
                                state  <= eeprom_pkg::FRAME_DATA; // R10
                                job_op <= eeprom_pkg::JOB_WRITE;
                            end
                            eeprom_pkg::OP_ERASE:
                            begin
                                state  <= eeprom_pkg::FRAME_ARMED; // R11
                                job_op <= eeprom_pkg::JOB_ERASE;
                            end
                            eeprom_pkg::OP_SPECIAL:
                            begin
                                if (sub == eeprom_pkg::SUB_WRITE_ALL)
                                begin
                                    state  <= eeprom_pkg::FRAME_DATA; // R12
                                    job_op <= eeprom_pkg::JOB_WRITE_ALL;
                                end
                                else if (sub == eeprom_pkg::SUB_ERASE_ALL)
                                begin
                                    state  <= eeprom_pkg::FRAME_ARMED; // R13
                                    job_op <= eeprom_pkg::JOB_ERASE_ALL;
                                end
                                else
                                    state <= eeprom_pkg::FRAME_HOLD;
                            end
                        endcase
                    end
                end
                eeprom_pkg::FRAME_DATA:
                begin
                    wdata <= {wdata[14:0], di_s}; // R10 R12
                    cnt   <= cnt + 1'b1;
                    if (cnt == 5'(eeprom_pkg::WORD_BITS - 1))
                        state <= eeprom_pkg::FRAME_ARMED;
                end
                eeprom_pkg::FRAME_ARMED:
                    state <= eeprom_pkg::FRAME_CANCEL; // R22
                eeprom_pkg::FRAME_READ:
                    state <= eeprom_pkg::FRAME_READ;
                eeprom_pkg::FRAME_CANCEL:
                    state <= eeprom_pkg::FRAME_CANCEL;
                eeprom_pkg::FRAME_HOLD:
                    state <= eeprom_pkg::FRAME_HOLD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // program enable latch
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            prog_enable <= 1'b0;
        else if (last_addr_clock && opcode == eeprom_pkg::OP_SPECIAL)
        begin
            if (sub == eeprom_pkg::SUB_PROG_ENABLE)
                prog_enable <= 1'b1; // R14
            else if (sub == eeprom_pkg::SUB_PROG_DISABLE)
                prog_enable <= 1'b0; // R15
        end
    end

    // ------------------------------------------------------------
    // job hand-off at end of frame
    // ------------------------------------------------------------
    eeprom_pkg::job_type in_job;
    eeprom_pkg::job_type out_job;
    logic                fifo_in_valid;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                eng_active;

    assign in_job.op   = job_op;
    assign in_job.addr = MAXA'(field[ADDR_BITS-1:0]);
    assign in_job.data = wdata;
    // only an exactly clocked frame, closed by select low, is kept
    assign fifo_in_valid = !cs_s && prog_enable && // R19
        state == eeprom_pkg::FRAME_ARMED; // R4 R22
    assign busy = eng_active || fifo_out_valid;

    job_fifo #(
        .WIDTH     (JOB_W),
        .DEPTH     (eeprom_pkg::FIFO_DEPTH)
    ) u_job_fifo (
        .clock     (CLOCK),
        .rst_n     (RST_N),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (in_job),
        .out_valid (fifo_out_valid),
        .out_ready (!eng_active),
        .out_data  (out_job)
    );

    // ------------------------------------------------------------
    // programming engine
    // ------------------------------------------------------------
    eeprom_pkg::job_type  eng_job;
    logic [CNT_W-1:0]     eng_count;
    logic [ADDR_BITS-1:0] sweep;
    logic                 eng_all;
    logic                 eng_done;

    assign eng_all  = eng_job.op == eeprom_pkg::JOB_WRITE_ALL ||
        eng_job.op == eeprom_pkg::JOB_ERASE_ALL;
    assign eng_done = eng_count == CNT_W'(WRITE_CYCLES - 1);
    assign mem_we    = eng_active && eng_done;
    assign mem_waddr = eng_all ? sweep : eng_job.addr[ADDR_BITS-1:0];
    assign mem_wdata = (eng_job.op == eeprom_pkg::JOB_ERASE ||
        eng_job.op == eeprom_pkg::JOB_ERASE_ALL) ?
        eeprom_pkg::ERASED_WORD : eng_job.data;

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            eng_active <= 1'b0;
            eng_job    <= '0;
            eng_count  <= '0;
            sweep      <= '0;
        end
        else if (!eng_active)
        begin
            if (fifo_out_valid)
            begin
                eng_active <= 1'b1;
                eng_job    <= out_job;
                eng_count  <= '0;
                sweep      <= '0;
            end
        end
        else if (!eng_done)
            eng_count <= eng_count + 1'b1;
        else if (eng_all && !(&sweep))
            sweep <= sweep + 1'b1; // R12 R13
        else
            eng_active <= 1'b0;
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [ADDR_BITS-1:0] rd_addr;
    logic [ADDR_BITS-1:0] rd_next;
    logic [15:0]          shreg;
    logic [3:0]           rcnt;

    assign rd_next = rd_addr + 1'b1;

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            rd_addr <= '0;
            shreg   <= '0;
            rcnt    <= '0;
        end
        else if (last_addr_clock && opcode == eeprom_pkg::OP_READ)
        begin
            rd_addr <= next_field[ADDR_BITS-1:0];
            shreg   <= mem[next_field[ADDR_BITS-1:0]];
            rcnt    <= '0;
        end
        else if (cs_s && sk_rise && state == eeprom_pkg::FRAME_READ)
        begin
            rcnt <= rcnt + 1'b1;
            if (&rcnt)
            begin
                rd_addr <= rd_next; // R17
                shreg   <= mem[rd_next];
            end
            else
                shreg <= {shreg[14:0], 1'b0}; // R9
        end
    end

    // ------------------------------------------------------------
    // serial output and verify status
    // ------------------------------------------------------------
    logic verify;

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            SERIAL_DATA_OUT    <= 1'b0;
            SERIAL_DATA_OUT_EN <= 1'b0;
            verify             <= 1'b0;
        end
        else if (!cs_s)
        begin
            SERIAL_DATA_OUT    <= 1'b0; // R6
            SERIAL_DATA_OUT_EN <= 1'b0;
            if (fifo_in_valid && fifo_in_ready)
                verify <= 1'b1;
        end
        else if (last_addr_clock && opcode == eeprom_pkg::OP_READ)
        begin
            SERIAL_DATA_OUT    <= 1'b0; // R21
            SERIAL_DATA_OUT_EN <= 1'b1;
        end
        else if (state == eeprom_pkg::FRAME_READ && sk_rise)
            SERIAL_DATA_OUT <= shreg[15]; // R2 R9
        else if (state == eeprom_pkg::FRAME_IDLE && verify)
        begin
            // a start bit on ready releases the pin
            if (sk_rise && di_s && !busy)
            begin
                SERIAL_DATA_OUT_EN <= 1'b0;
                verify             <= 1'b0;
            end
            else
            begin
                SERIAL_DATA_OUT_EN <= 1'b1; // R20
                SERIAL_DATA_OUT    <= !busy;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    sequence seq_read_addr_done;
        last_addr_clock && opcode == eeprom_pkg::OP_READ;
    endsequence

    sequence seq_drive_low;
        SERIAL_DATA_OUT_EN && !SERIAL_DATA_OUT &&
            state == eeprom_pkg::FRAME_READ;
    endsequence

    a_standby_quiet: assert property ( // R6
        !cs_s |=> !SERIAL_DATA_OUT_EN && state == eeprom_pkg::FRAME_IDLE)
        else $error("output or frame active while deselected");

    a_start_detect: assert property ( // R7
        state == eeprom_pkg::FRAME_IDLE && cs_s && sk_rise && di_s &&
        !busy |=> state == eeprom_pkg::FRAME_OPCODE)
        else $error("start bit not recognised");

    a_dummy_ignored: assert property ( // R8
        state == eeprom_pkg::FRAME_IDLE && sk_rise && !di_s
        |=> state == eeprom_pkg::FRAME_IDLE)
        else $error("leading zero clock left idle");

    a_read_low_drive: assert property ( // R21
        seq_read_addr_done |=> seq_drive_low)
        else $error("read did not drive low after address");

    a_out_on_edge: assert property ( // R2
        $changed(SERIAL_DATA_OUT) && $past(cs_s) && cs_s &&
        $past(state) == eeprom_pkg::FRAME_READ &&
        state == eeprom_pkg::FRAME_READ |-> $past(sk_rise))
        else $error("read data changed without clock rise");

    a_seq_advance: assert property ( // R17
        cs_s && sk_rise && state == eeprom_pkg::FRAME_READ && &rcnt
        |=> rd_addr == $past(rd_next) && rcnt == 4'h0)
        else $error("sequential read did not advance");

    a_protect_gate: assert property ( // R19
        !prog_enable && !busy |=> !fifo_out_valid)
        else $error("programming job queued while disabled");

    a_extra_cancel: assert property ( // R22
        cs_s && sk_rise && state == eeprom_pkg::FRAME_ARMED
        |=> state == eeprom_pkg::FRAME_CANCEL ##1 !fifo_in_valid)
        else $error("extra clock did not cancel write");

    a_verify_busy: assert property ( // R20
        cs_s && !sk_rise && verify && busy &&
        state == eeprom_pkg::FRAME_IDLE
        |=> SERIAL_DATA_OUT_EN && !SERIAL_DATA_OUT)
        else $error("busy not shown during verify");

    a_sweep_runs: assert property ( // R12
        mem_we && eng_all && !(&sweep) |=>
        mem_we && sweep == $past(sweep) + 1'b1)
        else $error("chip-wide sweep stalled");

endmodule

`default_nettype wire

/* sim/host_model.sv */
// host side driver of the three wire serial link
`default_nettype none

module host_model (
    input  wire logic CLOCK,
    input  wire logic DO_LINE,
    output logic      CS,
    output logic      SK,
    output logic      DI
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // pin drivers, changed at falling clock edges only
    // ------------------------------------------------------------
    initial
    begin
        CS = 1'b0;
        SK = 1'b0;
        DI = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge CLOCK);
    endtask

    // select low between frames for longer than the deselect time
    task automatic sel(input logic b);
        CS = b;
        idle(6);
    endtask

    // msb first; output sampled just before each rise
    task automatic shift(input logic [41:0] v, input int n,
                         output logic [32:0] got);
        got = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            DI = v[i];
            idle(6);
            got = {got[31:0], DO_LINE};
            SK = 1'b1;
            idle(6);
            SK = 1'b0;
        end
        DI = 1'b0;
    endtask
endmodule

`default_nettype wire

/* sim/serial_eeprom_tb.sv */
// self-checking bench of the serial word memory
`default_nettype none

module serial_eeprom_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock           = 1'b0;
    logic        rst_n           = 1'b0;
    logic        cs;
    logic        sk;
    logic        di;
    logic        out;
    logic        en;
    logic        last            = 1'b0;
    logic [32:0] g;
    int          num_errors      = 0;
    int          samples_checked = 0;
    int          cycles          = 0;
    // released line shows the inverse of its last driven level
    wire logic   do_line         = en ? out : ~last;

    always #12.5 clock = ~clock;

    serial_eeprom #(
        .ADDR_BITS          (6),
        .WRITE_CYCLES       (20)
    ) DUT (
        .CLOCK              (clock),
        .RST_N              (rst_n),
        .CHIP_SELECT        (cs),
        .SERIAL_CLOCK_IN    (sk),
        .SERIAL_DATA_IN     (di),
        .SERIAL_DATA_OUT    (out),
        .SERIAL_DATA_OUT_EN (en)
    );

    host_model host (
        .CLOCK   (clock),
        .DO_LINE (do_line),
        .CS      (cs),
        .SK      (sk),
        .DI      (di)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (en)
            last <= out;
        if (cycles == 30000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic run(input logic [41:0] v, input int n);
        host.sel(1'b1);
        host.shift(v, n, g);
        host.sel(1'b0);
        check({15'h0, en}, 16'h0);
    endtask

    // two words from address a onward
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        run(42'({1'b1, eeprom_pkg::OP_READ, a}) << 33, 42);
        check({15'h0, g[32]}, 16'h0);
        check(g[31:16], e[31:16]);
        check(g[15:0], e[15:0]);
    endtask

    task automatic cmd(input logic [1:0] op, input logic [5:0] f);
        run(42'({1'b1, op, f}), 9);
    endtask

    task automatic wr(input logic [1:0] op, input logic [5:0] f,
                      input logic [15:0] d, input int x);
        run(42'({1'b1, op, f, d}) << x, 25 + x);
    endtask

    task automatic done();
        host.sel(1'b1);
        check({15'h0, do_line}, 16'h0);
        for (int i = 0; i < 300 && do_line !== 1'b1; i++)
            host.idle(1);
        check({15'h0, do_line}, 16'h1);
        host.sel(1'b0);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_fresh();
        rd(6'h05, 32'hffffffff);
        wr(eeprom_pkg::OP_WRITE, 6'h05, 16'h1234, 0);
        host.idle(60);
        rd(6'h05, 32'hffffffff);
        $display("test fresh_locked done");
    endtask

    task automatic t_word();
        run(42'({1'b1, eeprom_pkg::OP_SPECIAL, 6'h30}), 12);
        wr(eeprom_pkg::OP_WRITE, 6'h05, 16'ha5c3, 0);
        done();
        rd(6'h05, 32'ha5c3ffff);
        cmd(eeprom_pkg::OP_ERASE, 6'h05);
        done();
        rd(6'h04, 32'hffffffff);
        $display("test word_ops done");
    endtask

    task automatic t_all();
        wr(eeprom_pkg::OP_SPECIAL, 6'h10, 16'h0f0f, 0);
        done();
        rd(6'h3f, 32'h0f0f0f0f);
        cmd(eeprom_pkg::OP_SPECIAL, 6'h20);
        done();
        rd(6'h3f, 32'hffffffff);
        $display("test all_ops done");
    endtask

    task automatic t_guard();
        wr(eeprom_pkg::OP_WRITE, 6'h02, 16'h0000, 1);
        host.idle(60);
        rd(6'h02, 32'hffffffff);
        host.shift(42'({1'b1, eeprom_pkg::OP_WRITE, 6'h02, 16'h0}), 25, g);
        host.sel(1'b1);
        host.shift(42'h5, 3, g);
        host.sel(1'b0);
        rd(6'h02, 32'hffffffff);
        cmd(eeprom_pkg::OP_SPECIAL, 6'h00);
        wr(eeprom_pkg::OP_WRITE, 6'h02, 16'h0000, 0);
        host.idle(60);
        rd(6'h02, 32'hffffffff);
        $display("test guards done");
    endtask

    // mid-run reset keeps the words but drops program enable
    task automatic t_reset();
        cmd(eeprom_pkg::OP_SPECIAL, 6'h30);
        wr(eeprom_pkg::OP_WRITE, 6'h07, 16'h5a5a, 0);
        done();
        rst_n = 1'b0;
        host.idle(2);
        rst_n = 1'b1;
        host.idle(4);
        rd(6'h07, 32'h5a5affff);
        wr(eeprom_pkg::OP_WRITE, 6'h07, 16'h0000, 0);
        host.idle(60);
        rd(6'h07, 32'h5a5affff);
        $display("test reset_keep done");
    endtask

    initial
    begin
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        host.idle(4);
        t_fresh();
        t_word();
        t_all();
        t_guard();
        t_reset();
        tally_and_finish();
    end
endmodule

`default_nettype wire
